/* tb_top.sv */
// Purpose: bench for the extended irq mask, priority and idle block
// Assumes: core model gives completion and acks
// Notes: reads are checked by a queue monitor
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, rd_d = 1'b0, ack_en = 1'b0;
  logic global_irq_enable = 1'b0, pin_reset_n = 1'b1;
  logic watchdog_reset = 1'b0;
  logic [7:0] ext_irq_enable_1 = 8'h00, src_pending = 8'h00;
  logic [7:0] src_pending_ext1 = 8'h00, sfr_rdata, ext_irq_enable_2;
  logic [7:0] ext_irq_priority_1, ext_irq_priority_2;
  logic sfr_hit, irq_req, irq_req_hi, core_halt, osc_stop, wake_reset;
  logic instr_done, irq_ack;
  logic [3:0] irq_vector_idx;
  xirq_pkg::xirq_mode_t power_mode;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  // watchdog pulsed once; otherwise idle may last as software left it
  xirq_ctrl uut (.clk_sys, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .sfr_hit, .global_irq_enable, .ext_irq_enable_1,
    .src_pending, .src_pending_ext1, .instr_done, .in_service_hi(1'b0),
    .in_service_lo(1'b0), .irq_ack, .pin_reset_n, .watchdog_reset,
    .irq_req, .irq_req_hi, .irq_vector_idx, .core_halt, .osc_stop,
    .wake_reset, .ext_irq_enable_2, .ext_irq_priority_1,
    .ext_irq_priority_2, .power_mode);
  xirq_core_model u_core (.clk_sys, .sfr_wr, .sfr_addr, .irq_req,
    .ack_en, .instr_done, .irq_ack);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read data lands one edge after the strobe
  always @(posedge clk_sys) rd_d <= sfr_rd;
  always @(negedge clk_sys) if (rd_d) chk(sfr_rdata, exp_q.pop_front());
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h8595));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(8'he7, 8'h00);
    rd(8'hf6, 8'h00);
    rd(8'hf7, 8'h00);
    rd(8'h55, 8'h00);
    repeat (3) begin
      v = 8'($urandom);
      wr(8'he7, v);
      rd(8'he7, v);
      wr(8'hf6, ~v);
      rd(8'hf6, ~v);
    end
    $display("test registers done");
    wr(8'hf7, 8'h00);
    src_pending <= 8'hff;
    global_irq_enable <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      wr(8'he7, 8'h01 << b);
      cyc(2);
      chk(irq_req, 1'b1);
      chk(irq_vector_idx, 8'(b + 8));
    end
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    cyc(2);
    chk(irq_req, 1'b0);
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    src_pending_ext1 <= 8'h01;
    ext_irq_enable_1 <= 8'h01;
    wr(8'hf6, 8'h00);
    cyc(2);
    chk(irq_vector_idx, 8'h00);
    wr(8'hf7, 8'h80);
    cyc(2);
    chk({irq_req_hi, irq_vector_idx}, 8'h1f);
    wr(8'hf6, 8'h01);
    cyc(2);
    chk({irq_req_hi, irq_vector_idx}, 8'h10);
    $display("test priority done");
    wr(8'he7, 8'h20);
    src_pending <= 8'h00;
    src_pending_ext1 <= 8'h00;
    wr(8'h87, 8'h01);
    cyc(2);
    chk({core_halt, 5'h00, power_mode}, 8'h81);
    rd(8'h87, 8'h00);
    wr(8'he7, 8'h00);
    rd(8'he7, 8'h20);
    src_pending <= 8'h20;
    ack_en <= 1'b1;
    cyc(2);
    chk(power_mode, 8'h00);
    @(posedge clk_sys);
    src_pending <= 8'h00;
    wr(8'h87, 8'h01);
    @(posedge clk_sys);
    pin_reset_n <= 1'b0;
    cyc(1);
    chk({wake_reset, ext_irq_enable_2[5], 4'h0, power_mode}, 8'h80);
    @(posedge clk_sys);
    pin_reset_n <= 1'b1;
    wr(8'h87, 8'h02);
    src_pending <= 8'hff;
    cyc(4);
    chk({osc_stop, 5'h00, power_mode}, 8'h82);
    @(posedge clk_sys);
    pin_reset_n <= 1'b0;
    @(posedge clk_sys);
    pin_reset_n <= 1'b1;
    cyc(2);
    chk(power_mode, 8'h00);
    wr(8'h87, 8'h01);
    @(posedge clk_sys);
    watchdog_reset <= 1'b1;
    @(posedge clk_sys);
    watchdog_reset <= 1'b0;
    cyc(0);
    chk({wake_reset, 5'h00, power_mode}, 8'h80);
    $display("test power modes done");
    end_of_test();
  end
endmodule

/* xirq_arbiter.sv */
// Purpose: pick one source by priority level, then fixed order
// Assumes: inputs already masked; index 0 is the highest in fixed order
// Notes: purely combinational, decoded each clock by the caller
`timescale 1ns/1ps
module xirq_arbiter #(
  parameter int NSRC = 16,
  parameter int IW = 4
) (
  input wire logic [NSRC-1:0] req,
  input wire logic [NSRC-1:0] prio,
  output logic any_hi,
  output logic any_lo,
  output logic [IW-1:0] hi_idx,
  output logic [IW-1:0] lo_idx
);
  // lowest index wins within a level
  always_comb begin
    any_hi = 1'b0;
    any_lo = 1'b0;
    hi_idx = '0;
    lo_idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && prio[i]) begin
        any_hi = 1'b1;
        hi_idx = IW'(i);
      end
      if (req[i] && !prio[i]) begin
        any_lo = 1'b1;
        lo_idx = IW'(i);
      end
    end
  end
endmodule

/* xirq_assertions.sv */
// Purpose: port checks for the extended irq block
// Assumes: bound to xirq_ctrl, one clock domain
// Notes: sync reset disables every check
`timescale 1ns/1ps
module xirq_chk #(
  parameter int NSRC = 16,
  parameter int IW = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic global_irq_enable,
  input wire logic [7:0] src_pending,
  input wire logic instr_done,
  input wire logic pin_reset_n,
  input wire logic watchdog_reset,
  input wire logic irq_req,
  input wire logic irq_req_hi,
  input wire logic [IW-1:0] irq_vector_idx,
  input wire logic core_halt,
  input wire logic osc_stop,
  input wire logic wake_reset,
  input wire logic [7:0] ext_irq_enable_2,
  input wire logic [7:0] ext_irq_priority_2,
  input wire xirq_pkg::xirq_mode_t power_mode
);
  // no reset source, so state may move
  wire ok = pin_reset_n & ~watchdog_reset;
  // a write is taken only in run mode
  wire wok = sfr_wr & ok & (power_mode == xirq_pkg::XIRQ_RUN);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_en2_write: assert property (wok && sfr_addr == 8'he7
    |=> ext_irq_enable_2 == $past(sfr_wdata)) else $error("enable lost");
  a_pri2_write: assert property (wok && sfr_addr == 8'hf7
    |=> ext_irq_priority_2 == $past(sfr_wdata)) else $error("prio lost");
  a_pwr_read_zero: assert property (sfr_rd && sfr_addr == 8'h87
    |=> sfr_rdata == 8'h00 && sfr_hit) else $error("power reg read");
  a_global_off: assert property (!global_irq_enable |=> !irq_req)
    else $error("request with global off");
  a_can_gate: assert property (irq_req && irq_vector_idx == 13
    |-> $past(ext_irq_enable_2[5] && src_pending[5]))
    else $error("can request not enabled");
  a_can_level: assert property (irq_req_hi && irq_vector_idx == 13
    |-> $past(ext_irq_priority_2[5])) else $error("can level wrong");
  a_idle_entry: assert property (wok && sfr_addr == 8'h87
    && sfr_wdata == 8'h01 ##1 instr_done && ok
    |=> power_mode == xirq_pkg::XIRQ_IDLE && core_halt)
    else $error("idle not entered");
  a_stop_osc: assert property (osc_stop
    |-> power_mode == xirq_pkg::XIRQ_STOP && core_halt)
    else $error("osc off outside stop");
  a_stop_holds: assert property (power_mode == xirq_pkg::XIRQ_STOP
    && ok |=> power_mode == xirq_pkg::XIRQ_STOP) else $error("stop left");
  a_pin_wake: assert property (power_mode != xirq_pkg::XIRQ_RUN
    && !pin_reset_n |=> power_mode == xirq_pkg::XIRQ_RUN && wake_reset)
    else $error("pin reset did not wake");
endmodule
bind xirq_ctrl xirq_chk #(.NSRC(NSRC), .IW(IW)) u_chk (.*);

/* xirq_core_model.sv */
// Purpose: core model answering the extended irq block
// Assumes: one-cycle write strobe
// Notes: acks only while the bench allows
`timescale 1ns/1ps
module xirq_core_model (
  input wire logic clk_sys,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic irq_req,
  input wire logic ack_en,
  output logic instr_done = 1'b0,
  output logic irq_ack = 1'b0
);
  // power write ends, next opcode is multibyte; ack is one pulse
  always @(posedge clk_sys) begin
    instr_done <= sfr_wr && sfr_addr == 8'h87;
    irq_ack <= ack_en && irq_req && !irq_ack;
  end
endmodule

/* xirq_ctrl.sv */
// Purpose: extended enable and priority registers plus idle/stop control
// Assumes: core drives a one-cycle sfr write strobe; read data is registered, one edge later
// Notes: source bits 15..8 use enable reg 2, 7..0 come from enable reg 1
`timescale 1ns/1ps
`include "xirq_defs.svh"
module xirq_ctrl #(
  parameter int NSRC = `XIRQ_NSRC,
  parameter int IW = `XIRQ_IDX_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic global_irq_enable,
  input wire logic [7:0] ext_irq_enable_1,
  input wire logic [7:0] src_pending,
  input wire logic [7:0] src_pending_ext1,
  input wire logic instr_done,
  input wire logic in_service_hi,
  input wire logic in_service_lo,
  input wire logic irq_ack,
  input wire logic pin_reset_n,
  input wire logic watchdog_reset,
  output logic irq_req,
  output logic irq_req_hi,
  output logic [IW-1:0] irq_vector_idx,
  output logic core_halt,
  output logic osc_stop,
  output logic wake_reset,
  output logic [7:0] ext_irq_enable_2,
  output logic [7:0] ext_irq_priority_1,
  output logic [7:0] ext_irq_priority_2,
  output xirq_pkg::xirq_mode_t power_mode
);
  typedef struct packed {
    logic [7:0] en2;
    logic [7:0] pri1;
    logic [7:0] pri2;
    xirq_pkg::xirq_mode_t mode;
    logic idle_arm;
    logic stop_arm;
    logic req;
    logic req_hi;
    logic [IW-1:0] idx;
    logic [7:0] rdata;
    logic hit;
    logic wake_rst;
  } xirq_state_t;

  xirq_state_t st;
  xirq_state_t next_st;

  logic [NSRC-1:0] masked;
  logic [NSRC-1:0] prio_vec;
  logic any_hi;
  logic any_lo;
  logic [IW-1:0] hi_idx;
  logic [IW-1:0] lo_idx;
  logic wake;
  logic ext_reset;

  // address decode for the read hit flag; writes decode in their own case
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `XIRQ_ADDR_EN2) || (a == `XIRQ_ADDR_PRI1) ||
                (a == `XIRQ_ADDR_PRI2) || (a == `XIRQ_ADDR_PWR);
  endfunction

  // mask sources by individual and global enable
  always_comb begin
    masked = '0;
    prio_vec = {st.pri2, st.pri1};
    for (int i = 0; i < 8; i++) begin
      masked[i] = src_pending_ext1[i] && ext_irq_enable_1[i] &&
                  global_irq_enable;
      masked[i+8] = src_pending[i] && st.en2[i] &&
                    global_irq_enable;
    end
  end

  xirq_arbiter #(
    .NSRC(NSRC),
    .IW(IW)
  ) u_arb (
    .req(masked),
    .prio(prio_vec),
    .any_hi(any_hi),
    .any_lo(any_lo),
    .hi_idx(hi_idx),
    .lo_idx(lo_idx)
  );

  assign wake = |masked;
  assign ext_reset = !pin_reset_n || watchdog_reset;

  // next-state logic for registers, mode and request
  always_comb begin
    next_st = st;
    next_st.wake_rst = 1'b0;
    next_st.hit = sfr_rd && is_mapped(sfr_addr);
    next_st.rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `XIRQ_ADDR_EN2: next_st.rdata = st.en2;
        `XIRQ_ADDR_PRI1: next_st.rdata = st.pri1;
        `XIRQ_ADDR_PRI2: next_st.rdata = st.pri2;
        `XIRQ_ADDR_PWR: next_st.rdata = `XIRQ_PWR_READ;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // writes are accepted only while the core runs
    if (sfr_wr && st.mode == xirq_pkg::XIRQ_RUN) begin
      unique case (sfr_addr)
        `XIRQ_ADDR_EN2: next_st.en2 = sfr_wdata;
        `XIRQ_ADDR_PRI1: next_st.pri1 = sfr_wdata;
        `XIRQ_ADDR_PRI2: next_st.pri2 = sfr_wdata;
        `XIRQ_ADDR_PWR: begin
          next_st.idle_arm = sfr_wdata[`XIRQ_BIT_IDLE];
          next_st.stop_arm = sfr_wdata[`XIRQ_BIT_STOP];
        end
        default: next_st.idle_arm = st.idle_arm;
      endcase
    end
    // mode sequencing
    unique case (st.mode)
      xirq_pkg::XIRQ_RUN: begin
        if (instr_done && st.stop_arm) begin
          next_st.mode = xirq_pkg::XIRQ_STOP;
          next_st.stop_arm = 1'b0;
          next_st.idle_arm = 1'b0;
        end else if (instr_done && st.idle_arm) begin
          next_st.mode = xirq_pkg::XIRQ_IDLE;
          next_st.idle_arm = 1'b0;
        end
      end
      xirq_pkg::XIRQ_IDLE: begin
        if (wake) begin
          next_st.mode = xirq_pkg::XIRQ_RUN;
        end
      end
      xirq_pkg::XIRQ_STOP: begin
        next_st.mode = xirq_pkg::XIRQ_STOP;
      end
      default: next_st.mode = xirq_pkg::XIRQ_RUN;
    endcase
    // request to core, decoded every cycle
    next_st.req = 1'b0;
    next_st.req_hi = 1'b0;
    next_st.idx = st.idx;
    if (st.mode != xirq_pkg::XIRQ_STOP && !in_service_hi && !irq_ack) begin
      if (any_hi) begin
        next_st.req = 1'b1;
        next_st.req_hi = 1'b1;
        next_st.idx = hi_idx;
      end else if (any_lo && !in_service_lo) begin
        next_st.req = 1'b1;
        next_st.idx = lo_idx;
      end
    end
    // any reset returns to a fresh start
    if (ext_reset) begin
      next_st.wake_rst = st.mode != xirq_pkg::XIRQ_RUN;
      next_st.mode = xirq_pkg::XIRQ_RUN;
      next_st.en2 = `XIRQ_RST_EN2;
      next_st.pri1 = `XIRQ_RST_PRI1;
      next_st.pri2 = `XIRQ_RST_PRI2;
      next_st.idle_arm = 1'b0;
      next_st.stop_arm = 1'b0;
      next_st.req = 1'b0;
      next_st.req_hi = 1'b0;
    end
  end

  // state register; idle leaves the enable and priority registers untouched
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st.en2 <= `XIRQ_RST_EN2;
      st.pri1 <= `XIRQ_RST_PRI1;
      st.pri2 <= `XIRQ_RST_PRI2;
      st.mode <= xirq_pkg::XIRQ_RUN;
      st.idle_arm <= 1'b0;
      st.stop_arm <= 1'b0;
      st.req <= 1'b0;
      st.req_hi <= 1'b0;
      st.idx <= '0;
      st.rdata <= 8'h00;
      st.hit <= 1'b0;
      st.wake_rst <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign sfr_rdata = st.rdata;
  assign sfr_hit = st.hit;
  assign irq_req = st.req;
  assign irq_req_hi = st.req_hi;
  assign irq_vector_idx = st.idx;
  assign core_halt = st.mode != xirq_pkg::XIRQ_RUN;
  assign osc_stop = st.mode == xirq_pkg::XIRQ_STOP;
  assign wake_reset = st.wake_rst;
  assign ext_irq_enable_2 = st.en2;
  assign ext_irq_priority_1 = st.pri1;
  assign ext_irq_priority_2 = st.pri2;
  assign power_mode = st.mode;
endmodule

/* xirq_defs.svh */
// Purpose: constants for the extended interrupt mask, priority and idle block
// Assumes: special-function bus with 8-bit data, addresses seen on all pages
// Notes: field positions count from bit 0
// Overview of operation
// - enable reg 2 at 0xE7, resets zero
// - enable bits: 1 enables, order dma..timer3
// - bit2 gates timer4, bit0 timer3 overflow
// - bit5 passes or blocks can requests
// - priority reg 1 at 0xF6, resets low
// - priority 1 bits select high per source
// - priority reg 2 at 0xF7, resets zero
// - priority 2 bits select high per source
// - two low-power modes; idle keeps peripherals
// - stop halts core, oscillator, interrupts, timers
// - idle bit write halts after instruction
// - idle keeps all registers and memory
// - enabled interrupt or reset pin ends idle
// - interrupt wake clears idle, resumes core
// - return resumes after idle-setting instruction
// - reset ends idle, fetch from zero
// - watchdog timeout reset ends idle
// - stopped oscillator restarts only by reset
// - high preempts low; fixed order breaks ties
// - global enable overrides all individual masks
// - requests sampled and decoded every cycle
// - idle and stop bits read zero
`ifndef XIRQ_DEFS_SVH
`define XIRQ_DEFS_SVH
`define XIRQ_ADDR_EN2 8'he7
`define XIRQ_ADDR_PRI1 8'hf6
`define XIRQ_ADDR_PRI2 8'hf7
`define XIRQ_ADDR_PWR 8'h87
`define XIRQ_RST_EN2 8'h00
`define XIRQ_RST_PRI1 8'h00
`define XIRQ_RST_PRI2 8'h00
`define XIRQ_PWR_READ 8'h00
`define XIRQ_BIT_IDLE 0
`define XIRQ_BIT_STOP 1
`define XIRQ_BIT_CAN 5
`define XIRQ_BIT_T4 2
`define XIRQ_BIT_T3 0
`define XIRQ_NSRC 16
`define XIRQ_IDX_W 4
`endif

/* xirq_pkg.sv */
// Purpose: types shared by the extended interrupt block
// Assumes: included constants header
// Notes: power modes are mutually exclusive
package xirq_pkg;
  typedef enum logic [1:0] {
    XIRQ_RUN = 2'b00,
    XIRQ_IDLE = 2'b01,
    XIRQ_STOP = 2'b10
  } xirq_mode_t;
endpackage
